// ---- lfp_lock_fuse.sv ----
// lock bit and extended fuse decode, programmer gating, self-store/load gating
// ---------------------------------------------------------------------------
// module
// ---------------------------------------------------------------------------
// Behaviour
// - six lock bits, erased only by chip erase or rst_n
// - general mode 1: no memory locking
// - mode 2: no programming, fuses locked
// - mode 3: no program/verify, boot locks locked
// - app mode 1: no store/load restriction
// - app mode 2: block stores to app
// - app mode 3: stores, boot loads, irqs blocked
// - app mode 4: boot loads, irqs blocked
// - boot mode 1: no store/load restriction
// - boot mode 2: block stores to boot
// - boot mode 3: stores, app loads, irqs blocked
// - boot mode 4: app loads, irqs blocked
// - three fuse bytes, programmed reads zero
// - brownout level from fuse bits 2..0
// - force fuse 1: normal port behaviour
// - force fuse 0: drive fuse-chosen level
// - forced level held until config written
// - A fuse 0 high, 1 low
// - B fuse 0 high, 1 low
// - extended fuses latched at power-up, prog entry and prog exit
// - low lock bit locks fuses; erase keeps fuses
module lfp_lock_fuse #(
    parameter int ADDR_W = 15  // program word address width
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    input  wire logic                          prog_mode,
    input  wire lfp_pkg::lfp_prg_cmd_t         prg_cmd,
    input  wire logic [7:0]                    prg_wdata,
    input  wire logic [1:0]                    prg_fuse_sel,
    output logic                               prg_grant,
    output logic [7:0]                         prg_rdata,
    input  wire logic [ADDR_W-1:0]             boot_start,
    input  wire logic                          vectors_in_boot,
    input  wire logic                          cpu_req,
    input  wire logic                          cpu_is_store,
    input  wire logic [ADDR_W-1:0]             cpu_pc,
    input  wire logic [ADDR_W-1:0]             cpu_target,
    output logic                               cpu_grant,
    output logic                               cpu_deny,
    output logic                               irq_block,
    input  wire logic                          stage_cfg_write,
    input  wire logic [2:0]                    stage_a_port,
    input  wire logic [2:0]                    stage_b_port,
    output logic [2:0]                         stage_output_a_channels,
    output logic [2:0]                         stage_output_b_channels,
    output logic [2:0]                         brownout_level,
    output logic                               eeprom_preserve
);
    import lfp_pkg::*;

    // -----------------------------------------------------------------------
    // nonvolatile storage
    // -----------------------------------------------------------------------
    logic [7:0] memory_lock_byte_q;          // live lock bits
    logic [7:0] extended_fuse_config_byte_q; // live extended fuses
    logic [7:0] fuse_hi_q;                   // high fuse byte storage
    logic [7:0] fuse_lo_q;                   // low fuse byte storage
    logic [7:0] efuse_latched_q;             // latched copy used by the logic
    logic       prog_mode_q;                 // previous programming mode
    logic       por_done_q;                  // power-up latch taken
    logic       eeprom_preserve_q;           // preserve fuse, acts at once
    logic       forcing_q;                   // stage outputs held forced
    logic [2:0] stage_a_q;                   // registered a outputs
    logic [2:0] stage_b_q;                   // registered b outputs
    logic [2:0] brownout_q;                  // registered brownout level
    logic       prg_grant_q;
    logic [7:0] prg_rdata_q;
    logic       cpu_grant_q;
    logic       cpu_deny_q;
    logic       irq_block_q;

    // -----------------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------------
    wire lfp_gen_mode_t gen_mode = lfp_gen_mode_t'({memory_lock_byte_q[GENERAL_LOCK_HI_BIT],
                                                    memory_lock_byte_q[GENERAL_LOCK_LO_BIT]});
    wire lfp_sec_mode_t app_mode = lfp_sec_mode_t'({memory_lock_byte_q[APP_SECTION_LOCK_HI],
                                                    memory_lock_byte_q[APP_SECTION_LOCK_LO]});
    wire lfp_sec_mode_t boot_mode = lfp_sec_mode_t'({memory_lock_byte_q[BOOT_SECTION_LOCK_HI],
                                                     memory_lock_byte_q[BOOT_SECTION_LOCK_LO]});

    // programmer restrictions; mode 1 leaves all open
    // reserved code 01 is treated as the stronger mode 2 for safety
    wire mem_write_locked = (gen_mode != LFP_GEN_MODE1);
    wire mem_read_locked  = (gen_mode == LFP_GEN_MODE3);
    wire boot_locks_locked = (gen_mode == LFP_GEN_MODE3);
    // either programmed general lock bit, low or high, locks fuses
    wire fuses_locked = ~memory_lock_byte_q[GENERAL_LOCK_LO_BIT]
                        | (gen_mode != LFP_GEN_MODE1);

    // -----------------------------------------------------------------------
    // programmer command decode
    // -----------------------------------------------------------------------
    wire is_mem_wr = prog_mode && (prg_cmd == LFP_PRG_MEM_WRITE);
    wire is_mem_rd = prog_mode && (prg_cmd == LFP_PRG_MEM_READ);
    wire is_fuse_wr = prog_mode && (prg_cmd == LFP_PRG_FUSE_WR);
    wire is_lock_wr = prog_mode && (prg_cmd == LFP_PRG_LOCK_WR);
    wire is_erase = prog_mode && (prg_cmd == LFP_PRG_ERASE);
    wire fuse_wr_ok = is_fuse_wr && !fuses_locked;
    wire prg_ok = (is_mem_wr && !mem_write_locked)
                  || (is_mem_rd && !mem_read_locked)
                  || fuse_wr_ok || is_lock_wr || is_erase;

    // lock write can only program bits (1 -> 0); boot bits frozen in mode 3
    wire [5:0] lock_keep_mask = boot_locks_locked ? 6'h0f : 6'h3f;
    wire [5:0] lock_cur = memory_lock_byte_q[LOCK_BITS-1:0];
    wire [5:0] lock_wr_val = lock_cur & (prg_wdata[5:0] | ~lock_keep_mask);
    wire [7:0] lock_next = is_erase ? {2'b11, LOCK_ERASED}
                         : is_lock_wr ? {2'b11, lock_wr_val}
                         : memory_lock_byte_q;

    // fuse read selection; programmed fuses read as zero directly
    wire [7:0] fuse_rd = (prg_fuse_sel == 2'd0) ? fuse_lo_q
                       : (prg_fuse_sel == 2'd1) ? fuse_hi_q
                       : (prg_fuse_sel == 2'd2) ? extended_fuse_config_byte_q
                       : memory_lock_byte_q;
    wire [7:0] rdata_next = (is_mem_rd && mem_read_locked) ? 8'h00 : fuse_rd;

    // -----------------------------------------------------------------------
    // self-programming section classification
    // -----------------------------------------------------------------------
    wire pc_in_boot  = (cpu_pc >= boot_start);
    wire tgt_in_boot = (cpu_target >= boot_start);
    wire tgt_mode_store_block = tgt_in_boot
        ? (boot_mode == LFP_SEC_MODE2 || boot_mode == LFP_SEC_MODE3)
        : (app_mode == LFP_SEC_MODE2 || app_mode == LFP_SEC_MODE3);
    wire app_load_block = !tgt_in_boot && pc_in_boot
        && (app_mode == LFP_SEC_MODE3 || app_mode == LFP_SEC_MODE4);
    wire boot_load_block = tgt_in_boot && !pc_in_boot
        && (boot_mode == LFP_SEC_MODE3 || boot_mode == LFP_SEC_MODE4);
    // mode 1 on both sections leaves every access through
    wire cpu_block = cpu_is_store ? tgt_mode_store_block
                                  : (app_load_block || boot_load_block);

    // interrupt suppression while executing from the far section
    wire irq_app = vectors_in_boot && !pc_in_boot
        && (app_mode == LFP_SEC_MODE3 || app_mode == LFP_SEC_MODE4);
    wire irq_boot = !vectors_in_boot && pc_in_boot
        && (boot_mode == LFP_SEC_MODE3 || boot_mode == LFP_SEC_MODE4);

    // -----------------------------------------------------------------------
    // fuse latching and stage outputs
    // -----------------------------------------------------------------------
    // latch on power-up and on entering or leaving programming mode; changes while in
    // programming mode only show after it is left
    wire prog_enter = prog_mode && !prog_mode_q;
    wire prog_leave = !prog_mode && prog_mode_q;
    wire latch_now  = !por_done_q || prog_enter || prog_leave;
    wire [7:0] efuse_next = fuse_wr_ok && (prg_fuse_sel == 2'd2)
                          ? prg_wdata : extended_fuse_config_byte_q;
    wire force_en  = ~efuse_latched_q[STAGE_FORCE_EN_BIT];
    // programmed level fuse (0) drives high, unprogrammed drives low
    wire a_level = ~efuse_latched_q[STAGE_A_LEVEL_BIT];
    wire b_level = ~efuse_latched_q[STAGE_B_LEVEL_BIT];

    // lock and fuse storage; chip erase never touches fuses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_lock_byte_q          <= LOCK_RESET;
            extended_fuse_config_byte_q <= EFUSE_RESET;
            fuse_hi_q                   <= 8'hff;
            fuse_lo_q                   <= 8'hff;
        end else if (clk_en) begin
            memory_lock_byte_q          <= lock_next;
            extended_fuse_config_byte_q <= efuse_next;
            if (fuse_wr_ok && prg_fuse_sel == 2'd1) begin
                fuse_hi_q <= prg_wdata;
            end
            if (fuse_wr_ok && prg_fuse_sel == 2'd0) begin
                fuse_lo_q <= prg_wdata;
            end
        end
    end

    // latched fuse copy and preserve fuse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            efuse_latched_q   <= EFUSE_RESET;
            prog_mode_q       <= 1'b0;
            por_done_q        <= 1'b0;
            eeprom_preserve_q <= 1'b0;
        end else if (clk_en) begin
            prog_mode_q       <= prog_mode;
            por_done_q        <= 1'b1;
            if (latch_now) begin
                efuse_latched_q <= extended_fuse_config_byte_q;
            end
            // preserve fuse is active low in the high byte, bit 3
            eeprom_preserve_q <= ~fuse_hi_q[3];
        end
    end

    // stage forcing: the asynchronous reset itself arms forcing, since a real
    // reset must drive the pins before any clock; the level is only known
    // from latched fuses, so reset value is low and the first edge corrects.
    // every fuse latch without a config write in the same cycle re-arms forcing, so a new force fuse takes effect at
    // the next latch point; only a config write releases it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            forcing_q <= 1'b1;
            stage_a_q <= 3'b000;
            stage_b_q <= 3'b000;
        end else if (clk_en) begin
            if (stage_cfg_write) begin
                forcing_q <= 1'b0;
            end else if (latch_now) begin
                forcing_q <= 1'b1;
            end
            if (forcing_q && force_en && !stage_cfg_write) begin
                stage_a_q <= {STAGE_CHANNELS{a_level}};
                stage_b_q <= {STAGE_CHANNELS{b_level}};
            end else begin
                stage_a_q <= stage_a_port;
                stage_b_q <= stage_b_port;
            end
        end
    end

    // registered answers to programmer and core
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prg_grant_q <= 1'b0;
            prg_rdata_q <= 8'h00;
            cpu_grant_q <= 1'b0;
            cpu_deny_q  <= 1'b0;
            irq_block_q <= 1'b0;
            brownout_q  <= 3'b111;
        end else if (clk_en) begin
            prg_grant_q <= prg_ok;
            prg_rdata_q <= rdata_next;
            cpu_grant_q <= cpu_req && !cpu_block;
            cpu_deny_q  <= cpu_req && cpu_block;
            irq_block_q <= irq_app || irq_boot;
            brownout_q  <= efuse_latched_q[BROWNOUT_MSB:BROWNOUT_LSB];
        end
    end

    // -----------------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------------
    assign prg_grant               = prg_grant_q;
    assign prg_rdata               = prg_rdata_q;
    assign cpu_grant               = cpu_grant_q;
    assign cpu_deny                = cpu_deny_q;
    assign irq_block               = irq_block_q;
    assign stage_output_a_channels = stage_a_q;
    assign stage_output_b_channels = stage_b_q;
    assign brownout_level          = brownout_q;
    assign eeprom_preserve         = eeprom_preserve_q;
endmodule : lfp_lock_fuse

// ---- lfp_pkg.sv ----
// package: lock byte and extended fuse byte layout, protection modes
package lfp_pkg;
    // lock byte field positions (1 = unprogrammed, 0 = programmed)
    localparam int GENERAL_LOCK_LO_BIT  = 0;
    localparam int GENERAL_LOCK_HI_BIT  = 1;
    localparam int APP_SECTION_LOCK_LO  = 2;
    localparam int APP_SECTION_LOCK_HI  = 3;
    localparam int BOOT_SECTION_LOCK_LO = 4;
    localparam int BOOT_SECTION_LOCK_HI = 5;
    localparam int LOCK_BITS            = 6;
    // extended fuse field positions
    localparam int BROWNOUT_LSB         = 0;
    localparam int BROWNOUT_MSB         = 2;
    localparam int STAGE_B_LEVEL_BIT    = 3;
    localparam int STAGE_A_LEVEL_BIT    = 4;
    localparam int STAGE_FORCE_EN_BIT   = 5;
    // reset values: everything unprogrammed
    localparam logic [7:0] LOCK_RESET   = 8'hff;
    localparam logic [7:0] EFUSE_RESET  = 8'hff;
    localparam logic [5:0] LOCK_ERASED  = 6'h3f;
    // stage output channel count per side
    localparam int STAGE_CHANNELS       = 3;

    // general protect mode, coded from {hi, lo}
    typedef enum logic [1:0] {
        LFP_GEN_MODE1 = 2'b11,
        LFP_GEN_MODE2 = 2'b10,
        LFP_GEN_MODE3 = 2'b00,
        LFP_GEN_RSVD  = 2'b01
    } lfp_gen_mode_t;

    // section protect mode, coded from {hi, lo}
    typedef enum logic [1:0] {
        LFP_SEC_MODE1 = 2'b11,
        LFP_SEC_MODE2 = 2'b10,
        LFP_SEC_MODE3 = 2'b00,
        LFP_SEC_MODE4 = 2'b01
    } lfp_sec_mode_t;

    // programmer access kinds
    typedef enum logic [2:0] {
        LFP_PRG_NONE      = 3'b000,
        LFP_PRG_MEM_WRITE = 3'b001,
        LFP_PRG_MEM_READ  = 3'b010,
        LFP_PRG_FUSE_WR   = 3'b011,
        LFP_PRG_LOCK_WR   = 3'b100,
        LFP_PRG_ERASE     = 3'b101
    } lfp_prg_cmd_t;
endpackage : lfp_pkg

// ---- lfp_lock_fuse_props.sv ----
// checker: port-level timing relations of the lock and fuse protection block
module lfp_lock_fuse_props
    import lfp_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  prog_mode,
    input wire lfp_pkg::lfp_prg_cmd_t prg_cmd,
    input wire logic                  prg_grant,
    input wire logic [7:0]            prg_rdata,
    input wire logic                  cpu_req,
    input wire logic                  cpu_grant,
    input wire logic                  cpu_deny,
    input wire logic [2:0]            stage_a_port,
    input wire logic [2:0]            stage_b_port,
    input wire logic [2:0]            stage_output_a_channels,
    input wire logic [2:0]            stage_output_b_channels
);
    // ------------------------------------------------------------------
    // one clock domain, so one default clocking and disable
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_cpu_one_answer: assert property (cpu_req |=> (cpu_grant ^ cpu_deny))
        else $error("access answer missing or doubled");
    a_cpu_no_stray: assert property (!cpu_req |=> !cpu_grant && !cpu_deny)
        else $error("access answer without request");
    a_prg_idle_quiet: assert property (!prog_mode |=> !prg_grant)
        else $error("programmer grant outside programming mode");
    // chip erase is never refused, whatever the lock state
    a_erase_always_ok: assert property (prog_mode && prg_cmd == LFP_PRG_ERASE |=> prg_grant)
        else $error("chip erase refused");
    a_lock_write_ok: assert property (prog_mode && prg_cmd == LFP_PRG_LOCK_WR |=> prg_grant)
        else $error("lock write refused");
    // a refused read must not leak memory contents
    a_read_refuse_zero: assert property (prog_mode && prg_cmd == LFP_PRG_MEM_READ
        |=> prg_grant || prg_rdata == 8'h00)
        else $error("refused read returned data");
    // outputs are either the forced uniform level or the port value a cycle late
    a_stage_a_level: assert property (!(stage_output_a_channels inside {3'b000, 3'b111})
        |-> stage_output_a_channels == $past(stage_a_port))
        else $error("stage A output neither forced nor port");
    a_stage_b_level: assert property (!(stage_output_b_channels inside {3'b000, 3'b111})
        |-> stage_output_b_channels == $past(stage_b_port))
        else $error("stage B output neither forced nor port");
endmodule : lfp_lock_fuse_props

bind lfp_lock_fuse lfp_lock_fuse_props u_props (.core_clk(core_clk), .rst_n(rst_n),
    .prog_mode(prog_mode), .prg_cmd(prg_cmd), .prg_grant(prg_grant), .prg_rdata(prg_rdata),
    .cpu_req(cpu_req), .cpu_grant(cpu_grant), .cpu_deny(cpu_deny),
    .stage_a_port(stage_a_port), .stage_b_port(stage_b_port),
    .stage_output_a_channels(stage_output_a_channels),
    .stage_output_b_channels(stage_output_b_channels));

// ---- lfp_core_model.sv ----
// partner model: processor core issuing program-memory store and load requests
module lfp_core_model
    import lfp_pkg::*;
#(
    parameter int ADDR_W = 15  // program word address width
) (
    input  wire logic         core_clk,
    output logic              cpu_req,
    output logic              cpu_is_store,
    output logic [ADDR_W-1:0] cpu_pc,
    output logic [ADDR_W-1:0] cpu_target
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------------
    initial begin
        cpu_req      = 1'b0;
        cpu_is_store = 1'b0;
        cpu_pc       = '0;
        cpu_target   = '0;
    end
    // one access held for a single taking edge; target address then inverted
    task automatic access(input logic st, input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] tg);
        @(posedge core_clk);
        #1;
        cpu_req      = 1'b1;
        cpu_is_store = st;
        cpu_pc       = pc;
        cpu_target   = tg;
        @(posedge core_clk);
        #1;
        cpu_req    = 1'b0;
        cpu_target = ~tg;  // no stale target once released
    endtask : access
endmodule : lfp_core_model

// ---- lfp_lock_fuse_tb.sv ----
// testbench: lock modes, programmer gating, section gating, stage output forcing
module lfp_lock_fuse_tb
    import lfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, clk_en, prog_mode, vib, stage_cfg_write, prg_grant, cpu_grant;
    logic cpu_deny, irq_block, eeprom_preserve, cpu_req, cpu_is_store, e;
    lfp_prg_cmd_t prg_cmd;
    logic [7:0]  prg_wdata, prg_rdata, ef;
    logic [1:0]  prg_fuse_sel;
    logic [14:0] boot_start, cpu_pc, cpu_target, pc, tg;
    logic [2:0]  stage_a_port, stage_b_port, st_a, st_b, brownout_level;
    logic [31:0] r;
    int mismatches, num_checks, cyc;
    lfp_lock_fuse DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .prog_mode(prog_mode),
        .prg_cmd(prg_cmd), .prg_wdata(prg_wdata), .prg_fuse_sel(prg_fuse_sel),
        .prg_grant(prg_grant), .prg_rdata(prg_rdata), .boot_start(boot_start),
        .vectors_in_boot(vib), .cpu_req(cpu_req), .cpu_is_store(cpu_is_store), .cpu_pc(cpu_pc),
        .cpu_target(cpu_target), .cpu_grant(cpu_grant), .cpu_deny(cpu_deny),
        .irq_block(irq_block), .stage_cfg_write(stage_cfg_write), .stage_a_port(stage_a_port),
        .stage_b_port(stage_b_port), .stage_output_a_channels(st_a),
        .stage_output_b_channels(st_b), .brownout_level(brownout_level),
        .eeprom_preserve(eeprom_preserve));
    lfp_core_model H (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_is_store(cpu_is_store),
        .cpu_pc(cpu_pc), .cpu_target(cpu_target));
    // ------------------------------------------------------------------
    // clock and hang guard (whole run is well under 2000 cycles)
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // programmer command for one taking edge; answer sampled just after that edge
    task automatic prg(input lfp_prg_cmd_t c, input logic [1:0] s, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        prg_cmd = c;
        prg_fuse_sel = s;
        prg_wdata = d;
        @(posedge core_clk);
        #1;
        prg_cmd = LFP_PRG_NONE;
        prg_wdata = ~d;
    endtask : prg
    // section rule: the target section's mode decides; loads only cross-section
    function automatic logic deny_exp(logic [1:0] am, logic [1:0] bm, logic st, logic pb, logic tb);
        logic [1:0] m;
        m = tb ? bm : am;
        return st ? !m[0] : (!m[1] && (pb != tb));
    endfunction : deny_exp
    initial begin
        r = $urandom(32'h1109);
        {rst_n, prog_mode, vib, stage_cfg_write, prg_wdata, prg_fuse_sel} = '0;
        clk_en = 1'b1;
        prg_cmd = LFP_PRG_NONE;
        boot_start = 15'h7000;
        stage_a_port = 3'($urandom);
        stage_b_port = 3'($urandom);
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk(st_a, stage_a_port);
        prog_mode = 1'b1;
        prg(LFP_PRG_MEM_READ, 2'd3, 8'h00);
        chk(prg_rdata, 8'hff);
        chk(brownout_level, 3'b111);
        ef = {3'b110, 5'($urandom)};
        prg(LFP_PRG_FUSE_WR, 2'd2, ef);
        chk(prg_grant, 1'b1);
        prg(LFP_PRG_MEM_READ, 2'd2, 8'h00);
        chk(prg_rdata, ef);
        chk(brownout_level, 3'b111);
        prg(LFP_PRG_FUSE_WR, 2'd1, 8'hf7);
        @(posedge core_clk);
        #1 chk(eeprom_preserve, 1'b1);
        prog_mode = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(brownout_level, ef[2:0]);
        {stage_a_port, stage_b_port} = 6'($urandom);
        repeat (3) @(posedge core_clk);
        #1 chk(st_a, {3{~ef[4]}});
        chk(st_b, {3{~ef[3]}});
        stage_cfg_write = 1'b1;
        @(posedge core_clk);
        #1 stage_cfg_write = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk({st_a, st_b}, {stage_a_port, stage_b_port});
        // every app/boot section mode pair, random accesses plus a boundary target
        for (int k = 0; k < 16; k++) begin
            prog_mode = 1'b1;
            prg(LFP_PRG_ERASE, 2'd3, 8'h00);
            prg(LFP_PRG_LOCK_WR, 2'd3, {2'b11, 4'(k), 2'b11});
            prog_mode = 1'b0;
            for (int j = 0; j < 6; j++) begin
                r = $urandom;
                boot_start = r[14:0] | 15'h0100;
                vib = r[15];
                pc = 15'($urandom);
                tg = (j == 0) ? boot_start : 15'($urandom);
                e = deny_exp(2'(k), 2'(k >> 2), r[16], pc >= boot_start, tg >= boot_start);
                H.access(r[16], pc, tg);
                chk({cpu_deny, cpu_grant}, {e, !e});
                chk(irq_block, (pc >= boot_start) ? (k < 8 && !vib) : (!k[1] && vib));
            end
        end
        // general lock modes 2 and 3, then erase
        prog_mode = 1'b1;
        prg(LFP_PRG_ERASE, 2'd3, 8'h00);
        prg(LFP_PRG_LOCK_WR, 2'd3, 8'hfe);
        prg(LFP_PRG_MEM_WRITE, 2'd0, 8'h5a);
        chk(prg_grant, 1'b0);
        prg(LFP_PRG_FUSE_WR, 2'd2, 8'h00);
        chk(prg_grant, 1'b0);
        prg(LFP_PRG_LOCK_WR, 2'd3, 8'hff);
        prg(LFP_PRG_MEM_READ, 2'd3, 8'h00);
        chk({prg_grant, prg_rdata}, 9'h1fe);
        prg(LFP_PRG_LOCK_WR, 2'd3, 8'hfc);
        prg(LFP_PRG_MEM_READ, 2'd0, 8'h00);
        chk({prg_grant, prg_rdata}, 9'h000);
        prg(LFP_PRG_ERASE, 2'd3, 8'h00);
        prg(LFP_PRG_MEM_READ, 2'd2, 8'h00);
        chk(prg_rdata, ef);
        complete_run();
    end
endmodule : lfp_lock_fuse_tb
